// file: verilog/spg_map.svh
`ifndef SPG_MAP_SVH
`define SPG_MAP_SVH
`define SPG_ADDR_MUX_A 16'h7090
`define SPG_ADDR_MUX_B 16'h7092
`define SPG_ADDR_PORT_A 16'h7098
`define SPG_ADDR_PORT_B 16'h709A
`define SPG_ADDR_PORT_C 16'h709C
`define SPG_ADDR_PORT_D 16'h709E
`define SPG_DATA_LSB 0
`define SPG_DIR_LSB 8
`define SPG_MUX_B_INVERT 16'h0103
`define SPG_MUX_B_USED 16'h03FF
`define SPG_RESET_VALUE 16'h0000
`endif

// file: verilog/spg_pkg.sv
package spg_pkg;
  typedef logic [15:0] spg_word_t;
  typedef logic [7:0] spg_byte_t;
endpackage : spg_pkg

// file: verilog/spg_port.sv
`timescale 1ns/100ps
`include "spg_map.svh"
// one 8-pin port: data/direction register, pin synchroniser and ownership mux
module spg_port
  import spg_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input wire logic wr_en,
  input wire spg_pkg::spg_word_t wr_data,
  output spg_pkg::spg_word_t rd_value,
  // ownership: 1 means general-purpose I/O owns the pin
  input wire logic [WIDTH-1:0] gpio_own,
  // peripheral side
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_oe,
  output logic [WIDTH-1:0] periph_in,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);
  import spg_pkg::*;

  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] dir_d;
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] pin_state_q;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] gpio_drive;
  logic [WIDTH-1:0] read_data;

  assign data_d = wr_en ? wr_data[`SPG_DATA_LSB +: WIDTH] : data_q;
  assign dir_d = wr_en ? wr_data[`SPG_DIR_LSB +: WIDTH] : dir_q;
  assign agree = ~(s2_q ^ s3_q);
  assign gpio_drive = gpio_own & dir_q;
  assign pin_out = (gpio_own & data_q) | (~gpio_own & periph_out);
  assign pin_oe = gpio_drive | (~gpio_own & periph_oe);
  // peripheral keeps seeing the pin even when GPIO owns it; harmless for inputs
  assign periph_in = pin_state_q;
  // input pins read the filtered pin level, outputs read the stored bit
  assign read_data = (dir_q & data_q) | (~dir_q & pin_state_q);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_q <= '0;
      dir_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_state_q <= '0;
      rd_value <= '0;
    end
    else
    begin
      data_q <= data_d;
      dir_q <= dir_d;
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_state_q <= (agree & s3_q) | (~agree & pin_state_q);
      rd_value <= '0;
      rd_value[`SPG_DATA_LSB +: WIDTH] <= read_data;
      rd_value[`SPG_DIR_LSB +: WIDTH] <= dir_q;
    end
  end
endmodule : spg_port

// file: verilog/spg_gpio_mux.sv
`timescale 1ns/100ps
`include "spg_map.svh"
// shared-pin GPIO multiplexer, ports A to D, on the core data bus
module spg_gpio_mux
  import spg_pkg::*;
#(
  // 1 builds the larger package with dedicated port D pins 2-7
  parameter bit LARGE_PACKAGE = 1'b1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core data-space access, read data valid the cycle after rd_en
  input wire spg_pkg::spg_word_t addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire spg_pkg::spg_word_t wr_data,
  output spg_pkg::spg_word_t rd_data,
  output logic rd_hit,
  // peripheral functions, bits 0-15 belong to select A bits 0-15, bits 16-25 to select B bits 0-9
  input wire logic [31:0] periph_out,
  input wire logic [31:0] periph_oe,
  output logic [31:0] periph_in,
  // pins: A[7:0], B[15:8], C[23:16], D[31:24]
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe
);
  import spg_pkg::*;

  spg_word_t mux_a_q;
  spg_word_t mux_b_q;
  spg_word_t mux_a_d;
  spg_word_t mux_b_d;
  spg_word_t rd_port [4];
  spg_word_t rd_sel;
  spg_word_t mux_b_norm;
  logic [31:0] gpio_own;
  logic [3:0] port_wr;
  logic sel_mux_a;
  logic sel_mux_b;
  logic [3:0] sel_port;
  logic [2:0] rd_src_q;
  logic rd_hit_q;
  logic [7:0] port_d_mask;
  logic wr_mux_a;
  logic wr_mux_b;
  logic sel_any;
  logic [2:0] rd_src_d;
  logic rd_hit_d;
  logic [7:0] port_d_out;
  logic [7:0] port_d_oe;
  spg_word_t rd_port_d;

  function automatic logic hit(input spg_word_t a, input spg_word_t base);
    hit = (a == base);
  endfunction : hit

  // priority from one-hot selects to a read-source code, 0 when nothing matches
  function automatic logic [2:0] read_code(input logic ma, input logic mb,
    input logic [3:0] pt);
    if (ma)
      read_code = 3'h1;
    else if (mb)
      read_code = 3'h2;
    else if (pt[0])
      read_code = 3'h4;
    else if (pt[1])
      read_code = 3'h5;
    else if (pt[2])
      read_code = 3'h6;
    else if (pt[3])
      read_code = 3'h7;
    else
      read_code = 3'h0;
  endfunction : read_code

  // address decode in data space
  assign sel_mux_a = hit(addr, `SPG_ADDR_MUX_A);
  assign sel_mux_b = hit(addr, `SPG_ADDR_MUX_B);
  assign sel_port[0] = hit(addr, `SPG_ADDR_PORT_A);
  assign sel_port[1] = hit(addr, `SPG_ADDR_PORT_B);
  assign sel_port[2] = hit(addr, `SPG_ADDR_PORT_C);
  assign sel_port[3] = hit(addr, `SPG_ADDR_PORT_D);
  assign port_wr = sel_port & {4{wr_en}};
  assign wr_mux_a = wr_en & sel_mux_a;
  assign wr_mux_b = wr_en & sel_mux_b;
  assign sel_any = sel_mux_a | sel_mux_b | (|sel_port);

  assign mux_a_d = wr_mux_a ? wr_data : mux_a_q;
  // bits 10-15 of select B have no pin and read zero
  assign mux_b_d = wr_mux_b ? (wr_data & `SPG_MUX_B_USED) : mux_b_q;
  // a read is answered one cycle later from the code latched here
  assign rd_src_d = rd_en ? read_code(sel_mux_a, sel_mux_b, sel_port) : 3'h0;
  assign rd_hit_d = rd_en & sel_any;

  // ownership: 1 = general-purpose I/O owns the pin
  assign gpio_own[15:0] = ~mux_a_q;
  // bring the reversed bits to the common 1 = peripheral sense first
  assign mux_b_norm = mux_b_q ^ `SPG_MUX_B_INVERT;
  assign gpio_own[23:16] = ~mux_b_norm[7:0];
  assign gpio_own[25:24] = ~mux_b_norm[9:8];
  // dedicated pins never hand over to a peripheral
  assign gpio_own[31:26] = 6'h3F;

  // small package: dedicated pins are absent, never driven, read zero
  assign port_d_mask = LARGE_PACKAGE ? 8'hFF : 8'h03;

  // port A: pins 0-7
  spg_port #(
    .WIDTH(8)
  ) u_port_a (
    .clk(clk),
    .rst(rst),
    .wr_en(port_wr[0]),
    .wr_data(wr_data),
    .rd_value(rd_port[0]),
    .gpio_own(gpio_own[7:0]),
    .periph_out(periph_out[7:0]),
    .periph_oe(periph_oe[7:0]),
    .periph_in(periph_in[7:0]),
    .pin_in(pin_in[7:0]),
    .pin_out(pin_out[7:0]),
    .pin_oe(pin_oe[7:0])
  );

  // port B: pins 8-15
  spg_port #(
    .WIDTH(8)
  ) u_port_b (
    .clk(clk),
    .rst(rst),
    .wr_en(port_wr[1]),
    .wr_data(wr_data),
    .rd_value(rd_port[1]),
    .gpio_own(gpio_own[15:8]),
    .periph_out(periph_out[15:8]),
    .periph_oe(periph_oe[15:8]),
    .periph_in(periph_in[15:8]),
    .pin_in(pin_in[15:8]),
    .pin_out(pin_out[15:8]),
    .pin_oe(pin_oe[15:8])
  );

  // port C: pins 16-23
  spg_port #(
    .WIDTH(8)
  ) u_port_c (
    .clk(clk),
    .rst(rst),
    .wr_en(port_wr[2]),
    .wr_data(wr_data),
    .rd_value(rd_port[2]),
    .gpio_own(gpio_own[23:16]),
    .periph_out(periph_out[23:16]),
    .periph_oe(periph_oe[23:16]),
    .periph_in(periph_in[23:16]),
    .pin_in(pin_in[23:16]),
    .pin_out(pin_out[23:16]),
    .pin_oe(pin_oe[23:16])
  );

  // port D: pins 24-31, the upper six only exist on the large package
  spg_port #(
    .WIDTH(8)
  ) u_port_d (
    .clk(clk),
    .rst(rst),
    .wr_en(port_wr[3]),
    .wr_data(wr_data),
    .rd_value(rd_port[3]),
    .gpio_own(gpio_own[31:24]),
    .periph_out(periph_out[31:24]),
    .periph_oe(periph_oe[31:24]),
    .periph_in(periph_in[31:24]),
    .pin_in(pin_in[31:24]),
    .pin_out(port_d_out),
    .pin_oe(port_d_oe)
  );

  // gating after the port keeps one port module for every package
  assign pin_out[31:24] = port_d_out & port_d_mask;
  assign pin_oe[31:24] = port_d_oe & port_d_mask;
  assign rd_port_d = rd_port[3] & {port_d_mask, port_d_mask};

  // read mux one cycle after rd_en; port registers already come from flops
  always_comb
  begin
    unique case (rd_src_q)
      3'h1: rd_sel = mux_a_q;
      3'h2: rd_sel = mux_b_q;
      3'h4: rd_sel = rd_port[0];
      3'h5: rd_sel = rd_port[1];
      3'h6: rd_sel = rd_port[2];
      3'h7: rd_sel = rd_port_d;
      default: rd_sel = '0;
    endcase
  end
  assign rd_data = rd_sel;
  assign rd_hit = rd_hit_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mux_a_q <= `SPG_RESET_VALUE;
      mux_b_q <= `SPG_RESET_VALUE;
      rd_src_q <= 3'h0;
      rd_hit_q <= 1'b0;
    end
    else
    begin
      mux_a_q <= mux_a_d;
      mux_b_q <= mux_b_d;
      // both read outputs come from flops and stand for exactly one cycle
      rd_hit_q <= rd_hit_d;
      rd_src_q <= rd_src_d;
    end
  end
endmodule : spg_gpio_mux

// file: sim/spg_pin_model.sv
`timescale 1ns/100ps
// outside world: a driven pin shows its drive, a released pin shows ext
module spg_pin_model
(
  // drive from the block
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  // level of the board where nothing drives
  input wire logic [31:0] ext,
  // pin levels
  output logic [31:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : spg_pin_model

// file: sim/spg_gpio_mux_sva.sv
`timescale 1ns/100ps
module spg_gpio_mux_sva
  import spg_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'h1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core bus
  input wire spg_pkg::spg_word_t addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire spg_pkg::spg_word_t wr_data,
  input wire spg_pkg::spg_word_t rd_data,
  input wire logic rd_hit,
  // peripherals and pins
  input wire logic [31:0] periph_out,
  input wire logic [31:0] periph_oe,
  input wire logic [31:0] periph_in,
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire map = addr inside {16'h7090, 16'h7092, 16'h7098, 16'h709A, 16'h709C, 16'h709E};
  wire wa = wr_en && addr == 16'h7090;
  wire wd = wr_en && addr == 16'h709E && LARGE_PACKAGE;
  property p_hit; rd_en |=> rd_hit == $past(map); endproperty
  a_hit: assert property (p_hit) else $error("rd_hit wrong");
  property p_idle; !rd_en |=> rd_data == 16'h0000 && !rd_hit; endproperty
  a_idle: assert property (p_idle) else $error("idle rd_data");
  property p_miss; rd_en && !map |=> rd_data == 16'h0000; endproperty
  a_miss: assert property (p_miss) else $error("unmapped rd_data");
  property p_ma; wa ##1 !wr_en ##1 rd_en && addr == 16'h7090 |=> rd_data == $past(wr_data, 3);
  endproperty
  a_ma: assert property (p_ma) else $error("select A readback");
  property p_mb; wr_en && addr == 16'h7092 ##1 !wr_en ##1 rd_en && addr == 16'h7092
    |=> rd_data == ($past(wr_data, 3) & 16'h03FF); endproperty
  a_mb: assert property (p_mb) else $error("select B readback");
  property p_own; wa && wr_data == 16'hFFFF |=> pin_oe[15:0] == periph_oe[15:0]; endproperty
  a_own: assert property (p_own) else $error("peripheral not owning");
  property p_dd; wd |=> pin_oe[31:26] == $past(wr_data[15:10]); endproperty
  a_dd: assert property (p_dd) else $error("port D direction");
  property p_do; wd |=> (pin_out[31:26] & pin_oe[31:26]) == ($past(wr_data[7:2]) & pin_oe[31:26]);
  endproperty
  a_do: assert property (p_do) else $error("port D data");
  property p_pd; wr_en && addr == 16'h7098 ##1 !wr_en ##1 rd_en && addr == 16'h7098
    |=> rd_data[15:8] == $past(wr_data[15:8], 3); endproperty
  a_pd: assert property (p_pd) else $error("port A direction readback");
  c_own: cover property (wa && wr_data == 16'hFFFF);
  c_miss: cover property (rd_en && !map);
  c_rd: cover property (rd_en && addr == 16'h709E);
endmodule : spg_gpio_mux_sva
bind spg_gpio_mux spg_gpio_mux_sva #(.LARGE_PACKAGE(LARGE_PACKAGE)) u_sva (.clk(clk), .rst(rst),
  .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
  .rd_hit(rd_hit), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import spg_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic wr_en = 1'h0;
  logic rd_en = 1'h0;
  logic rd_hit;
  spg_word_t addr = 16'h0000;
  spg_word_t wr_data = 16'h0000;
  spg_word_t rd_data, ma, mb;
  spg_word_t p [4];
  logic [31:0] periph_out = 32'h0, periph_oe = 32'h0, ext = 32'h0;
  logic [31:0] periph_in, pin_in, pin_out, pin_oe, g, dir, dat, eoe, eout, lvl;
  logic [31:0] sm_out, sm_oe;
  spg_word_t sm_rd;
  int fails = 0;
  int compares = 0;
  int seed = 32'h6FCC;
  always #2.5 clk = ~clk;
  spg_gpio_mux u_dut (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  spg_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  // small package twin on the same bus and pins
  spg_gpio_mux #(.LARGE_PACKAGE(1'b0)) u_dut_small (.clk(clk), .rst(rst), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(sm_rd), .rd_hit(),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(), .pin_in(pin_in),
    .pin_out(sm_out), .pin_oe(sm_oe));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude;
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic wr(spg_word_t a, spg_word_t v);
    @(negedge clk);
    addr = a;
    wr_data = v;
    wr_en = 1'h1;
    @(negedge clk);
    wr_en = 1'h0;
  endtask : wr
  task automatic rd(spg_word_t a, spg_word_t e, logic h);
    @(negedge clk);
    addr = a;
    rd_en = 1'h1;
    @(negedge clk);
    rd_en = 1'h0;
    chk("rd_data", 32'(rd_data), 32'(e));
    chk("rd_hit", 32'(rd_hit), 32'(h));
    chk("small_rd", 32'(sm_rd), 32'(a == 16'h709E ? e & 16'h0303 : e));
  endtask : rd
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'h0;
    // six mapped words after reset, then one hole past the last
    for (int i = 0; i < 7; i++)
      rd(16'h7090 + 16'(2 * i) + (i > 1 ? 16'h0004 : 16'h0000), 16'h0000, i < 6);
    for (int k = 0; k < 24; k++)
    begin
      ma = k == 0 ? 16'h0000 : k == 1 ? 16'hFFFF : 16'($random(seed));
      mb = k == 0 ? 16'h0103 : k == 1 ? 16'hFEFC : 16'($random(seed));
      periph_out = $random(seed);
      periph_oe = $random(seed);
      ext = $random(seed);
      wr(16'h7090, ma);
      rd(16'h7090, ma, 1'h1);
      wr(16'h7092, mb);
      rd(16'h7092, mb & 16'h03FF, 1'h1);
      foreach (p[i])
      begin
        p[i] = 16'($random(seed));
        wr(16'h7098 + 16'(2 * i), p[i]);
      end
      // a stray write to a hole must leave every register alone
      wr(16'h70A0, 16'($random(seed)));
      repeat (6) @(negedge clk);
      dir = {p[3][15:8], p[2][15:8], p[1][15:8], p[0][15:8]};
      dat = {p[3][7:0], p[2][7:0], p[1][7:0], p[0][7:0]};
      g = {6'h3F, ~mb[9], mb[8], ~(mb[7:0] ^ 8'h03), ~ma};
      eoe = (g & dir) | (~g & periph_oe);
      eout = (g & dat) | (~g & periph_out);
      lvl = (eoe & eout) | (~eoe & ext);
      chk("pin_oe", pin_oe, eoe);
      chk("pin_out", pin_out & eoe, eout & eoe);
      chk("periph_in", periph_in, lvl);
      chk("small_d_pins", 32'({sm_oe[31:26], sm_out[31:26]}), 32'h0);
      lvl = (dir & dat) | (~dir & lvl);
      foreach (p[i])
      begin
        wr(16'h7098 + 16'(2 * i), p[i]);
        rd(16'h7098 + 16'(2 * i), {p[i][15:8], lvl[8 * i +: 8]}, 1'h1);
      end
    end
    conclude();
  end
endmodule : testbench
